//--- bench/halfword_load_unit_tb.sv
// self-checking bench for the halfword load unit
`default_nettype none
module halfword_load_unit_tb;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {
        logic [31:0] insn;
        logic [31:0] base;
        logic [31:0] idx;
        logic [15:0] hw;
        logic [31:0] addr;
        logic [31:0] rt;
        logic        ra_we;
    } hlu_row_t;
    logic        clk_sys_i, arst_n_i, issue_i, busy_o, illegal_o, mem_req_o, mem_ack_i;
    logic        mem_dsi_i, fault_align_o, fault_dsi_o, rt_we_o, ra_we_o, done_o, dsi_cmd;
    logic [31:0] insn_i, base_val_i, index_val_i, mem_addr_o, rt_data_o, ra_data_o, s_addr;
    logic [15:0] mem_data_i, hw_cmd;
    logic [4:0]  rt_sel_o, ra_sel_o;
    logic [3:0]  lat_cmd;
    int          err_total, n_tests, nreq;
    hlu_row_t    rows [9];
    halfword_load_unit uut (.clk_sys_i, .arst_n_i, .issue_i, .insn_i, .base_val_i,
        .index_val_i, .busy_o, .illegal_o, .mem_req_o, .mem_addr_o, .mem_ack_i, .mem_data_i,
        .mem_dsi_i, .fault_align_o, .fault_dsi_o, .rt_we_o, .rt_sel_o, .rt_data_o, .ra_we_o,
        .ra_sel_o, .ra_data_o, .done_o);
    hlu_mem_model mem (.clk_i(clk_sys_i), .req_i(mem_req_o), .lat_i(lat_cmd), .hw_i(hw_cmd),
        .dsi_i(dsi_cmd), .ack_o(mem_ack_i), .data_o(mem_data_i), .dsi_o(mem_dsi_i));
    ////////////////////////////////////////////////////////////////////////////////
    // clock
    always #25 clk_sys_i = ~clk_sys_i;
    // compare and count
    task automatic check(input logic [39:0] got, input logic [39:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic wrap_up();
        $display("checks %0d errors %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : wrap_up
    // one load: issue, count request cycles, stop at done
    task automatic run(input logic [31:0] insn, base, idx, input logic [15:0] hw,
                       input logic [3:0] lat, input logic dsi);
        int k;
        lat_cmd = lat;
        hw_cmd = hw;
        dsi_cmd = dsi;
        {insn_i, base_val_i, index_val_i} = {insn, base, idx};
        issue_i = 1'b1;
        @(posedge clk_sys_i);
        #2;
        issue_i = 1'b0;
        nreq = 0;
        s_addr = 32'h0;
        for (k = 0; k < 40 && done_o !== 1'b1; k++) begin
            if (mem_req_o === 1'b1) begin
                nreq++;
                s_addr = mem_addr_o;
            end
            @(posedge clk_sys_i);
            #2;
        end
        if (k == 40) begin
            check(40'h0, 40'h1);
            wrap_up();
        end
    endtask : run
    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        {clk_sys_i, arst_n_i, issue_i, insn_i, base_val_i, index_val_i} = '0;
        {err_total, n_tests, lat_cmd, hw_cmd, dsi_cmd} = '0;
        rows = '{
            '{32'h7cc522ae, 32'h1000, 32'h0234, 16'h8001, 32'h1234, 32'hffff8001, 1'b0},
            '{32'h7cc522af, 32'h1000, 32'h0234, 16'h0001, 32'h1234, 32'h00000001, 1'b0},
            '{32'h7cc5262c, 32'h1000, 32'h0234, 16'h7654, 32'h1234, 32'h00005476, 1'b0},
            '{32'ha0c5fffe, 32'h1000, 32'h0000, 16'hffff, 32'h0ffe, 32'h0000ffff, 1'b0},
            '{32'ha4c50010, 32'h2000, 32'h0000, 16'h8000, 32'h2010, 32'h00008000, 1'b1},
            '{32'h7cc02296, 32'h1000, 32'h0234, 16'habcd, 32'h0234, 32'h0000abcd, 1'b0},
            '{32'h7cc5222e, 32'h1000, 32'h0234, 16'h1111, 32'h1234, 32'h00001111, 1'b0},
            '{32'ha4a50010, 32'h2000, 32'h0000, 16'h2222, 32'h2010, 32'h00002222, 1'b0},
            '{32'ha0c00010, 32'h1000, 32'h0000, 16'h4444, 32'h0010, 32'h00004444, 1'b0}};
        repeat (8) @(posedge clk_sys_i);
        #2;
        check({busy_o, mem_req_o, done_o, rt_we_o, ra_we_o}, 40'h0);
        arst_n_i = 1'b1;
        // table rows, back to back, short and long memory latency
        for (int i = 0; i < 9; i++) begin
            run(rows[i].insn, rows[i].base, rows[i].idx, rows[i].hw, i[0] ? 4'h4 : 4'h1, 1'b0);
            check(s_addr, rows[i].addr);
            check(rt_data_o, rows[i].rt);
            check({rt_we_o, rt_sel_o}, {1'b1, rows[i].insn[25:21]});
            check(ra_we_o, rows[i].ra_we);
            if (rows[i].ra_we) check({ra_sel_o, ra_data_o}, {rows[i].insn[20:16], s_addr});
            check(nreq, i[0] ? 5 : 2);
            check({busy_o, mem_req_o}, 40'h0);
        end
        // odd address with update: no access, no writes
        run(32'ha4c50010, 32'h2001, 32'h0, 16'h1, 4'h1, 1'b0);
        check({fault_align_o, rt_we_o, ra_we_o, nreq[3:0]}, 40'h40);
        // storage fault on indexed update
        run(32'h7cc52296, 32'h1000, 32'h0234, 16'h1, 4'h2, 1'b1);
        check({fault_dsi_o, rt_we_o, ra_we_o}, 40'h4);
        // opcode outside the family
        run(32'ha8c50000, 32'h1000, 32'h0, 16'h1, 4'h1, 1'b0);
        check({illegal_o, rt_we_o, nreq[3:0]}, 40'h20);
        wrap_up();
    end
endmodule : halfword_load_unit_tb
`default_nettype wire

//--- bench/hlu_assertions.sv
// port assertions for the halfword load unit
`default_nettype none
module hlu_assertions (
    input wire logic        clk_sys_i,
    input wire logic        arst_n_i,
    input wire logic        issue_i,
    input wire logic        busy_o,
    input wire logic        illegal_o,
    input wire logic        mem_req_o,
    input wire logic [31:0] mem_addr_o,
    input wire logic        mem_ack_i,
    input wire logic [15:0] mem_data_i,
    input wire logic        mem_dsi_i,
    input wire logic        fault_align_o,
    input wire logic        fault_dsi_o,
    input wire logic        rt_we_o,
    input wire logic [4:0]  rt_sel_o,
    input wire logic [31:0] rt_data_o,
    input wire logic        ra_we_o,
    input wire logic [4:0]  ra_sel_o,
    input wire logic [31:0] ra_data_o,
    input wire logic        done_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!arst_n_i);
    ////////////////////////////////////////////////////////////////////////////////
    chk_issue_answer: assert property (
        issue_i && !busy_o |=> mem_req_o || illegal_o || fault_align_o)
        else $error("issue got no answer");
    chk_req_cause: assert property ($rose(mem_req_o) |-> $past(issue_i))
        else $error("request without issue");
    chk_addr_hold: assert property (mem_req_o && $past(mem_req_o) |-> $stable(mem_addr_o))
        else $error("address moved during request");
    chk_req_busy: assert property (mem_req_o |-> busy_o)
        else $error("request while not busy");
    chk_ack_result: assert property (
        mem_ack_i && busy_o && !mem_dsi_i |=> rt_we_o && done_o && !busy_o && !mem_req_o)
        else $error("no target write after ack");
    chk_dsi_nowrite: assert property (
        mem_ack_i && busy_o && mem_dsi_i |=> fault_dsi_o && done_o && !rt_we_o && !ra_we_o)
        else $error("write despite storage fault");
    chk_align_noreq: assert property (
        fault_align_o |-> done_o && !mem_req_o && !rt_we_o && !ra_we_o)
        else $error("alignment fault with access or write");
    chk_base_update: assert property (
        ra_we_o |-> ra_sel_o != 5'h00 && ra_sel_o != rt_sel_o && rt_we_o
        && ra_data_o == $past(mem_addr_o))
        else $error("bad base update");
    chk_data_form: assert property (
        rt_we_o |-> (rt_data_o[15:0] == $past(mem_data_i)
        || rt_data_o[15:0] == {$past(mem_data_i[7:0]), $past(mem_data_i[15:8])})
        && (rt_data_o[31:16] == 16'h0000
        || (rt_data_o[31:16] == 16'hffff && rt_data_o[15])))
        else $error("bad target data form");
endmodule : hlu_assertions
bind halfword_load_unit hlu_assertions u_chk (.*);
`default_nettype wire

//--- bench/hlu_mem_model.sv
// memory port model answering one halfword per request
`default_nettype none
module hlu_mem_model (
    input  wire logic        clk_i,
    input  wire logic        req_i,
    input  wire logic [3:0]  lat_i,
    input  wire logic [15:0] hw_i,
    input  wire logic        dsi_i,
    output var logic         ack_o,
    output var logic [15:0]  data_o,
    output var logic         dsi_o
);
    timeunit 1ns;
    timeprecision 100ps;
    int   cnt;
    logic sent;
    // idle at time zero
    initial begin
        ack_o = 1'b0;
        data_o = 16'h5a5a;
        dsi_o = 1'b0;
        sent = 1'b0;
    end
    // ack after lat_i waiting cycles, once per request
    always @(posedge clk_i) begin
        #2;
        ack_o = 1'b0;
        data_o = ~data_o; // released bus toggles
        dsi_o = ~dsi_i;
        if (req_i !== 1'b1) begin
            cnt = 0;
            sent = 1'b0;
        end else if (!sent && cnt == int'(lat_i)) begin
            ack_o = 1'b1;
            data_o = hw_i;
            dsi_o = dsi_i;
            sent = 1'b1;
        end else begin
            cnt++;
        end
    end
endmodule : hlu_mem_model
`default_nettype wire

//--- verilog/halfword_load_unit.sv
// halfword load unit: decode, address, memory request, result and write-back
`default_nettype none
`include "hlu_params.svh"
module halfword_load_unit (
    input  wire logic        clk_sys_i,
    input  wire logic        arst_n_i,
    input  wire logic        issue_i,
    input  wire logic [31:0] insn_i,
    input  wire logic [31:0] base_val_i,
    input  wire logic [31:0] index_val_i,
    output logic             busy_o,
    output logic             illegal_o,
    output logic             mem_req_o,
    output logic [31:0]      mem_addr_o,
    input  wire logic        mem_ack_i,
    input  wire logic [15:0] mem_data_i,
    input  wire logic        mem_dsi_i,
    output logic             fault_align_o,
    output logic             fault_dsi_o,
    output logic             rt_we_o,
    output logic [4:0]       rt_sel_o,
    output logic [31:0]      rt_data_o,
    output logic             ra_we_o,
    output logic [4:0]       ra_sel_o,
    output logic [31:0]      ra_data_o,
    output logic             done_o
);
    typedef enum logic [1:0] {ST_IDLE, ST_WAIT} hlu_st_t;

    hlu_pkg::hlu_dec_t dec;
    logic [31:0]       ea;

    hlu_decode u_decode (
        .insn_i (insn_i),
        .dec_o  (dec)
    );

    hlu_addr u_addr (
        .base_i              (base_val_i),
        .index_i             (index_val_i),
        .disp_i              (dec.disp),
        .base_sel_i          (dec.base_register_select),
        .indexed_i           (dec.indexed),
        .effective_address_o (ea)
    );

    ////////////////////////////////////////////////////////////////////////////
    // state
    hlu_st_t           st_r, st_nxt;
    hlu_pkg::hlu_dec_t op_r, op_nxt;
    logic [31:0]       ea_r, ea_nxt;
    logic              req_r, req_nxt;
    logic              ill_r, ill_nxt;
    logic              fal_r, fal_nxt;
    logic              fds_r, fds_nxt;
    logic              done_r, done_nxt;
    hlu_pkg::hlu_wb_t  rt_r, rt_nxt;
    hlu_pkg::hlu_wb_t  ra_r, ra_nxt;
    logic [31:0]       res;

    // result placement per form
    always_comb begin
        unique case (op_r.op)
            hlu_pkg::HLU_OP_ALG_X:  res = {{16{mem_data_i[15]}}, mem_data_i};
            hlu_pkg::HLU_OP_SWAP_X: res = {16'h0000, mem_data_i[7:0],
                                           mem_data_i[15:8]};
            default:                res = {16'h0000, mem_data_i};
        endcase
    end

    // sequencer: one request per load, results wait for the ack
    always_comb begin
        st_nxt   = st_r;
        op_nxt   = op_r;
        ea_nxt   = ea_r;
        req_nxt  = req_r;
        ill_nxt  = 1'b0;
        fal_nxt  = 1'b0;
        fds_nxt  = 1'b0;
        done_nxt = 1'b0;
        rt_nxt   = '0;
        ra_nxt   = '0;
        // exception register and condition field have no port at all
        unique case (st_r)
            ST_IDLE: begin
                if (issue_i) begin
                    if (dec.op == hlu_pkg::HLU_OP_NONE) begin
                        ill_nxt  = 1'b1;
                        done_nxt = 1'b1;
                    end else if ((ea & `HLU_ALIGN_MASK) != 32'h00000000) begin
                        fal_nxt  = 1'b1;                // no access, no update
                        done_nxt = 1'b1;
                    end else begin
                        op_nxt  = dec;
                        ea_nxt  = ea;
                        req_nxt = 1'b1;                 // single halfword read
                        st_nxt  = ST_WAIT;
                    end
                end
            end
            ST_WAIT: begin
                if (mem_ack_i) begin
                    req_nxt  = 1'b0;
                    st_nxt   = ST_IDLE;
                    done_nxt = 1'b1;
                    if (mem_dsi_i) begin
                        fds_nxt = 1'b1;
                    end else begin
                        rt_nxt.we   = 1'b1;             // write only on data return
                        rt_nxt.sel  = op_r.target_register_select;
                        rt_nxt.data = res;
                        if (op_r.update &&
                            op_r.base_register_select != `HLU_REG_ZERO &&
                            op_r.base_register_select != op_r.target_register_select) begin
                            ra_nxt.we   = 1'b1;
                            ra_nxt.sel  = op_r.base_register_select;
                            ra_nxt.data = ea_r;
                        end
                    end
                end
            end
        endcase
    end

    // registers
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_r   <= ST_IDLE;
            op_r   <= '0;
            ea_r   <= 32'h00000000;
            req_r  <= 1'b0;
            ill_r  <= 1'b0;
            fal_r  <= 1'b0;
            fds_r  <= 1'b0;
            done_r <= 1'b0;
            rt_r   <= '0;
            ra_r   <= '0;
        end else begin
            st_r   <= st_nxt;
            op_r   <= op_nxt;
            ea_r   <= ea_nxt;
            req_r  <= req_nxt;
            ill_r  <= ill_nxt;
            fal_r  <= fal_nxt;
            fds_r  <= fds_nxt;
            done_r <= done_nxt;
            rt_r   <= rt_nxt;
            ra_r   <= ra_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs straight from flops
    assign busy_o        = req_r;           // request flop is high exactly in the wait state
    assign mem_req_o     = req_r;
    assign mem_addr_o    = ea_r;
    assign illegal_o     = ill_r;
    assign fault_align_o = fal_r;
    assign fault_dsi_o   = fds_r;
    assign done_o        = done_r;
    assign rt_we_o       = rt_r.we;
    assign rt_sel_o      = rt_r.sel;
    assign rt_data_o     = rt_r.data;
    assign ra_we_o       = ra_r.we;
    assign ra_sel_o      = ra_r.sel;
    assign ra_data_o     = ra_r.data;
endmodule : halfword_load_unit
`default_nettype wire

//--- verilog/hlu_addr.sv
// effective address adder
`default_nettype none
`include "hlu_params.svh"
module hlu_addr (
    input  wire logic [31:0] base_i,
    input  wire logic [31:0] index_i,
    input  wire logic [15:0] disp_i,
    input  wire logic [4:0]  base_sel_i,
    input  wire logic        indexed_i,
    output logic      [31:0] effective_address_o
);
    logic [31:0] base_term;
    logic [31:0] off_term;
    // zero base select means no base contribution
    always_comb begin
        base_term = (base_sel_i == `HLU_REG_ZERO) ? 32'h00000000 : base_i;
        off_term  = indexed_i ? index_i : {{16{disp_i[15]}}, disp_i};
        effective_address_o = base_term + off_term;
    end
endmodule : hlu_addr
`default_nettype wire

//--- verilog/hlu_decode.sv
// field decoder for the halfword loads
`default_nettype none
`include "hlu_params.svh"
module hlu_decode (
    input  wire logic [31:0]     insn_i,
    output hlu_pkg::hlu_dec_t    dec_o
);
    logic [5:0] prim;
    logic [9:0] xo;
    // bit 0 of the instruction is the msb, so bit n sits at index 31-n
    assign prim = insn_i[31:26];
    assign xo   = insn_i[10:1];          // bit 31 (index 0) ignored

    // classify opcode and pull register fields
    always_comb begin
        dec_o = '0;
        dec_o.target_register_select = insn_i[25:21];
        dec_o.base_register_select   = insn_i[20:16];
        dec_o.index_register_select  = insn_i[15:11];
        dec_o.disp                   = insn_i[15:0];
        dec_o.op                     = hlu_pkg::HLU_OP_NONE;
        if (prim == `HLU_OP_LHZ) begin
            dec_o.op = hlu_pkg::HLU_OP_ZERO_D;
        end else if (prim == `HLU_OP_LHZU) begin
            dec_o.op     = hlu_pkg::HLU_OP_ZERO_DU;
            dec_o.update = 1'b1;
        end else if (prim == `HLU_OP_EXT) begin
            dec_o.indexed = 1'b1;
            if (xo == `HLU_XO_LHAX) begin
                dec_o.op = hlu_pkg::HLU_OP_ALG_X;
            end else if (xo == `HLU_XO_SWAP) begin
                dec_o.op = hlu_pkg::HLU_OP_SWAP_X;
            end else if (xo == `HLU_XO_ZUX) begin
                dec_o.op     = hlu_pkg::HLU_OP_ZERO_XU;
                dec_o.update = 1'b1;
            end else if (xo == `HLU_XO_ZX) begin
                dec_o.op = hlu_pkg::HLU_OP_ZERO_X;
            end else begin
                dec_o.indexed = 1'b0;
            end
        end
    end
endmodule : hlu_decode
`default_nettype wire

//--- verilog/hlu_params.svh
// constants for the halfword load unit
`ifndef HLU_PARAMS_SVH
`define HLU_PARAMS_SVH
`define HLU_OP_EXT       6'h1f
`define HLU_OP_LHZ       6'h28
`define HLU_OP_LHZU      6'h29
`define HLU_XO_LHAX      10'h157
`define HLU_XO_SWAP      10'h316
`define HLU_XO_ZUX       10'h14b
`define HLU_XO_ZX        10'h117
`define HLU_REG_ZERO     5'h00
`define HLU_ALIGN_MASK   32'h00000001
`endif

//--- verilog/hlu_pkg.sv
// types shared by the halfword load unit
`default_nettype none
package hlu_pkg;
    typedef enum logic [2:0] {
        HLU_OP_NONE,
        HLU_OP_ALG_X,
        HLU_OP_SWAP_X,
        HLU_OP_ZERO_D,
        HLU_OP_ZERO_DU,
        HLU_OP_ZERO_XU,
        HLU_OP_ZERO_X
    } hlu_op_t;

    typedef struct packed {
        hlu_op_t    op;
        logic [4:0] target_register_select;
        logic [4:0] base_register_select;
        logic [4:0] index_register_select;
        logic [15:0] disp;
        logic       indexed;
        logic       update;
    } hlu_dec_t;

    typedef struct packed {
        logic        we;
        logic [4:0]  sel;
        logic [31:0] data;
    } hlu_wb_t;
endpackage : hlu_pkg
`default_nettype wire
